// *** inc/smspi_pkg.sv ***
// Package with shared constants and types for the serial memory SPI link.
package smspi_pkg;
	// ==========================================================
	// Link format
	localparam int unsigned SMSPI_BYTE_W = 8;
	localparam int unsigned SMSPI_ADDR_W = 19;
	localparam int unsigned SMSPI_ADDR_BYTES = 3;
	localparam int unsigned SMSPI_ADDR_DROP = 5;
	localparam int unsigned SMSPI_MEM_DEPTH = 524288;
	localparam logic [7:0] SMSPI_STATUS_RST = 8'h00;
	localparam int unsigned SMSPI_LOCK_BIT = 7;
	// ==========================================================
	// Opcodes
	localparam logic [7:0] SMSPI_OP_WREN = 8'h06;
	localparam logic [7:0] SMSPI_OP_WRDI = 8'h04;
	localparam logic [7:0] SMSPI_OP_RDSR = 8'h05;
	localparam logic [7:0] SMSPI_OP_WRSR = 8'h01;
	localparam logic [7:0] SMSPI_OP_WRITE = 8'h02;
	localparam logic [7:0] SMSPI_OP_READ = 8'h03;
	// ==========================================================
	// Timing
	localparam int unsigned SMSPI_CLK_MHZ = 20;
	localparam int unsigned SMSPI_SCK_MAX_MHZ = 20;
	// Serial clock half period is this count plus one core cycle.
	// Six cycles cover the round trip through both ends' synchronisers and the output flop.
	localparam logic [3:0] SMSPI_HALF_DIV = 4'h5;
	// ==========================================================
	// Device phase
	typedef enum logic [2:0] {
		SMSPI_D_IDLE = 3'h0,
		SMSPI_D_OPC = 3'h1,
		SMSPI_D_ADDR = 3'h3,
		SMSPI_D_DATA = 3'h2,
		SMSPI_D_IGNORE = 3'h6
	} smspi_dev_state_t;
	// Host phase
	typedef enum logic [1:0] {
		SMSPI_H_IDLE = 2'h0,
		SMSPI_H_SHIFT = 2'h1,
		SMSPI_H_LAST = 2'h3,
		SMSPI_H_GAP = 2'h2
	} smspi_host_state_t;
endpackage

// *** inc/smspi_if.sv ***
// Interface joining the serial memory device and the SPI master.
`timescale 1ns/100ps
interface smspi_if;
	logic cs_n;
	logic sck;
	logic mosi;
	logic miso_o;
	logic miso_oe;
	logic wp_n;
	logic miso;
	// Undriven output floats high on the wire.
	assign miso = miso_oe ? miso_o : 1'b1;
	modport device (
		input cs_n,
		input sck,
		input mosi,
		input wp_n,
		output miso_o,
		output miso_oe
	);
	modport host (
		output cs_n,
		output sck,
		output mosi,
		output wp_n,
		input miso
	);
endinterface // smspi_if

// *** rtl/smspi_sync.sv ***
// Two-stage synchroniser for one level from outside the core clock.
`timescale 1ns/100ps
module smspi_sync #(
	parameter logic RST_VAL = 1'b0
) (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	input wire logic async_i,
	output logic sync_o
);
	logic meta_reg;
	// ==========================================================
	// Synchroniser
	// The first stage is read only by the second stage.
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			meta_reg <= RST_VAL;
			sync_o <= RST_VAL;
		end else if (ce_i) begin
			meta_reg <= async_i;
			sync_o <= meta_reg;
		end
	end
endmodule // smspi_sync

// *** rtl/smspi_device.sv ***
// Device end: serial memory SPI slave front end with byte array and status.
//
// Functional notes
// - Low select activates device and clock input.
// - High select: standby, ignore inputs, output off.
// - Master drops select before every opcode.
// - Capture on rising, change on falling edge.
// - Any clock rate, pauses keep state; the clock is sampled here, so it must stay well below the core rate.
// - Serial input matters only at rising edge.
// - Output driven only while returning read data.
// - Input and output may share one wire.
// - Lock bit plus low guard blocks status write.
// - Array holds 524288 byte locations.
// - Each byte crosses as eight serial bits.
// - Access is select, opcode, three address bytes.
// - Each byte written immediately, no busy time.
// - Modes 0 and 3 only, capture from first rise.
// - First byte opcode, then address, then data.
// - Master releases select after each operation.
// - First five address bits are discarded.
// - Clock level at select picks mode.
// - Unknown opcode ignored until next select.
// - Eight-bit status register holds lock bit.
`timescale 1ns/100ps
module smspi_device (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	smspi_if.device link,
	output logic selected_o,
	output logic [7:0] status_o,
	output logic write_enable_o,
	output logic spi_mode3_o
);
	typedef struct packed {
		smspi_pkg::smspi_dev_state_t st;
		logic cs_d;
		logic sck_d;
		logic [2:0] bit_cnt;
		logic [7:0] shift_in;
		logic [7:0] shift_out;
		logic [7:0] opcode;
		logic [1:0] addr_cnt;
		logic [23:0] addr;
		logic [7:0] status;
		logic wel;
		logic mode3;
		logic drive;
		logic miso;
		logic rd_pend;
		logic sel;
	} smspi_dev_t;

	smspi_dev_t s_reg;
	smspi_dev_t s_next;
	logic cs_s;
	logic sck_s;
	logic mosi_s;
	logic wp_s;
	logic [7:0] mem [0:smspi_pkg::SMSPI_MEM_DEPTH-1];
	logic mem_we;
	logic [18:0] mem_wa;
	logic [7:0] mem_wd;
	logic [18:0] mem_ra;
	logic [7:0] mem_rd;

	// ==========================================================
	// Pin synchronisers
	// The serial clock is sampled, so it must stay well below the core rate.
	smspi_sync #(.RST_VAL(1'b1)) u_cs (.core_clk_i(core_clk_i), .reset_i(reset_i),
		.ce_i(ce_i), .async_i(link.cs_n), .sync_o(cs_s));
	smspi_sync #(.RST_VAL(1'b0)) u_sck (.core_clk_i(core_clk_i), .reset_i(reset_i),
		.ce_i(ce_i), .async_i(link.sck), .sync_o(sck_s));
	smspi_sync #(.RST_VAL(1'b0)) u_mosi (.core_clk_i(core_clk_i), .reset_i(reset_i),
		.ce_i(ce_i), .async_i(link.mosi), .sync_o(mosi_s));
	smspi_sync #(.RST_VAL(1'b1)) u_wp (.core_clk_i(core_clk_i), .reset_i(reset_i),
		.ce_i(ce_i), .async_i(link.wp_n), .sync_o(wp_s));

	// ==========================================================
	// Memory array
	// Read port is asynchronous so a byte is ready by the next falling edge.
	assign mem_rd = mem[mem_ra];
	always_ff @(posedge core_clk_i) begin
		if (ce_i && mem_we) begin
			mem[mem_wa] <= mem_wd;
		end
	end

	// ==========================================================
	// Protocol engine
	always_comb begin
		logic rise;
		logic fall;
		logic [7:0] byte_in;
		rise = 1'b0;
		fall = 1'b0;
		byte_in = 8'h00;
		s_next = s_reg;
		mem_we = 1'b0;
		mem_wa = s_reg.addr[18:0];
		mem_wd = 8'h00;
		mem_ra = s_reg.addr[18:0];
		s_next.cs_d = cs_s;
		s_next.sck_d = sck_s;
		s_next.sel = !cs_s;
		rise = sck_s && !s_reg.sck_d;
		fall = !sck_s && s_reg.sck_d;
		byte_in = {s_reg.shift_in[6:0], mosi_s};
		if (cs_s) begin
			// Deselected: standby, everything else ignored.
			s_next.st = smspi_pkg::SMSPI_D_IDLE;
			s_next.drive = 1'b0;
			s_next.rd_pend = 1'b0;
		end else if (s_reg.cs_d) begin
			// Fresh selection restarts framing and picks the mode.
			s_next.st = smspi_pkg::SMSPI_D_OPC;
			s_next.mode3 = sck_s;
			s_next.bit_cnt = 3'h0;
			s_next.addr_cnt = 2'h0;
			s_next.drive = 1'b0;
			s_next.rd_pend = 1'b0;
		end else if (s_reg.st != smspi_pkg::SMSPI_D_IGNORE) begin
			if (rise) begin
				// Only the rising edge looks at the serial input.
				s_next.shift_in = byte_in;
				s_next.bit_cnt = s_reg.bit_cnt + 3'h1;
			end
			if (rise && s_reg.bit_cnt == 3'h7) begin
				case (s_reg.st)
					smspi_pkg::SMSPI_D_OPC: begin
						s_next.opcode = byte_in;
						case (byte_in)
							smspi_pkg::SMSPI_OP_WREN: begin
								s_next.wel = 1'b1;
								s_next.st = smspi_pkg::SMSPI_D_IGNORE;
							end
							smspi_pkg::SMSPI_OP_WRDI: begin
								s_next.wel = 1'b0;
								s_next.st = smspi_pkg::SMSPI_D_IGNORE;
							end
							smspi_pkg::SMSPI_OP_RDSR: begin
								s_next.st = smspi_pkg::SMSPI_D_DATA;
								s_next.shift_out = s_reg.status;
								s_next.rd_pend = 1'b1;
							end
							smspi_pkg::SMSPI_OP_WRSR: begin
								s_next.st = smspi_pkg::SMSPI_D_DATA;
							end
							smspi_pkg::SMSPI_OP_WRITE,
							smspi_pkg::SMSPI_OP_READ: begin
								s_next.st = smspi_pkg::SMSPI_D_ADDR;
							end
							default: begin
								s_next.st = smspi_pkg::SMSPI_D_IGNORE;
							end
						endcase
					end
					smspi_pkg::SMSPI_D_ADDR: begin
						s_next.addr = {s_reg.addr[15:0], byte_in};
						s_next.addr_cnt = s_reg.addr_cnt + 2'h1;
						if (s_reg.addr_cnt == 2'h2) begin
							// Top five bits are cleared and never used.
							s_next.addr[23:19] = 5'h00;
							s_next.st = smspi_pkg::SMSPI_D_DATA;
							s_next.rd_pend = (s_reg.opcode == smspi_pkg::SMSPI_OP_READ);
						end
					end
					smspi_pkg::SMSPI_D_DATA: begin
						if (s_reg.opcode == smspi_pkg::SMSPI_OP_WRITE) begin
							mem_we = s_reg.wel;
							mem_wd = byte_in;
							s_next.addr = {5'h00, s_reg.addr[18:0] + 19'h00001};
						end else if (s_reg.opcode == smspi_pkg::SMSPI_OP_WRSR) begin
							if (s_reg.wel && !(s_reg.status[smspi_pkg::SMSPI_LOCK_BIT] && !wp_s)) begin
								s_next.status = byte_in;
							end
						end else if (s_reg.opcode == smspi_pkg::SMSPI_OP_READ) begin
							s_next.addr = {5'h00, s_reg.addr[18:0] + 19'h00001};
							s_next.rd_pend = 1'b1;
						end else begin
							s_next.rd_pend = 1'b1;
						end
					end
					default: begin
						s_next.st = smspi_pkg::SMSPI_D_IGNORE;
					end
				endcase
			end
			// Output changes on the falling edge only; first bit of a byte loads it.
			if (fall && s_reg.rd_pend) begin
				s_next.drive = 1'b1;
				if (s_reg.bit_cnt == 3'h0) begin
					if (s_reg.opcode == smspi_pkg::SMSPI_OP_READ) begin
						s_next.miso = mem_rd[7];
						s_next.shift_out = {mem_rd[6:0], 1'b0};
					end else begin
						s_next.miso = s_reg.status[7];
						s_next.shift_out = {s_reg.status[6:0], 1'b0};
					end
				end else begin
					s_next.miso = s_reg.shift_out[7];
					s_next.shift_out = {s_reg.shift_out[6:0], 1'b0};
				end
			end
		end else begin
			s_next.drive = 1'b0;
		end
	end

	// ==========================================================
	// State register
	// A frozen clock enable holds the whole struct, so link pauses are safe.
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			s_reg <= '{st: smspi_pkg::SMSPI_D_IDLE, cs_d: 1'b1, status: smspi_pkg::SMSPI_STATUS_RST,
				default: '0};
		end else if (ce_i) begin
			s_reg <= s_next;
		end
	end

	// Output enable is low during every input phase, so one shared wire works.
	assign link.miso_o = s_reg.miso;
	assign link.miso_oe = s_reg.drive;
	assign selected_o = s_reg.sel;
	assign status_o = s_reg.status;
	assign write_enable_o = s_reg.wel;
	assign spi_mode3_o = s_reg.mode3;
endmodule // smspi_device

// *** rtl/smspi_host.sv ***
// Host end: SPI master that shifts one byte per user request and holds the selection until the last byte.
`timescale 1ns/100ps
module smspi_host (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	smspi_if.host link,
	input wire logic start_i,
	input wire logic [7:0] tx_byte_i,
	input wire logic last_i,
	input wire logic mode3_i,
	input wire logic wp_n_i,
	output logic busy_o,
	output logic byte_done_o,
	output logic [7:0] rx_byte_o
);
	typedef struct packed {
		smspi_pkg::smspi_host_state_t st;
		logic cs_n;
		logic sck;
		logic mosi;
		logic [3:0] div;
		logic [2:0] bit_cnt;
		logic [7:0] tx;
		logic [7:0] rx;
		logic last;
		logic done;
		logic [7:0] rx_out;
		logic wp_n;
		logic busy;
	} smspi_host_t;

	smspi_host_t h_reg;
	smspi_host_t h_next;
	logic miso_s;

	smspi_sync #(.RST_VAL(1'b1)) u_miso (.core_clk_i(core_clk_i), .reset_i(reset_i),
		.ce_i(ce_i), .async_i(link.miso), .sync_o(miso_s));

	// ==========================================================
	// Master engine
	// A byte is requested with start_i; last_i ends the selection after it.
	always_comb begin
		h_next = h_reg;
		h_next.done = 1'b0;
		h_next.wp_n = wp_n_i;
		if (h_reg.div != 4'h0) begin
			h_next.div = h_reg.div - 4'h1;
		end
		case (h_reg.st)
			smspi_pkg::SMSPI_H_IDLE: begin
				h_next.sck = mode3_i;
				if (start_i) begin
					// Every operation starts with a fresh select fall.
					h_next.cs_n = 1'b0;
					h_next.tx = {tx_byte_i[6:0], 1'b0};
					h_next.mosi = tx_byte_i[7];
					h_next.last = last_i;
					h_next.bit_cnt = 3'h0;
					h_next.div = smspi_pkg::SMSPI_HALF_DIV;
					h_next.st = smspi_pkg::SMSPI_H_SHIFT;
				end
			end
			smspi_pkg::SMSPI_H_SHIFT: begin
				if (h_reg.div == 4'h0) begin
					h_next.div = smspi_pkg::SMSPI_HALF_DIV;
					h_next.sck = !h_reg.sck;
					if (!h_reg.sck) begin
						// Rising edge: the device captures, the host samples too.
						h_next.rx = {h_reg.rx[6:0], miso_s};
						if (h_reg.bit_cnt == 3'h7) begin
							h_next.st = smspi_pkg::SMSPI_H_LAST;
						end
						h_next.bit_cnt = h_reg.bit_cnt + 3'h1;
					end else if (h_reg.bit_cnt != 3'h0) begin
						// In mode 3 the first fall comes before any rise and must not shift.
						h_next.mosi = h_reg.tx[7];
						h_next.tx = {h_reg.tx[6:0], 1'b0};
					end
				end
			end
			smspi_pkg::SMSPI_H_LAST: begin
				if (h_reg.div == 4'h0) begin
					h_next.done = 1'b1;
					h_next.rx_out = h_reg.rx;
					h_next.div = smspi_pkg::SMSPI_HALF_DIV;
					if (h_reg.last) begin
						h_next.sck = mode3_i;
						h_next.st = smspi_pkg::SMSPI_H_GAP;
					end else begin
						// Drop the clock and pause until the next byte comes.
						h_next.sck = 1'b0;
						h_next.st = smspi_pkg::SMSPI_H_IDLE;
					end
				end
			end
			smspi_pkg::SMSPI_H_GAP: begin
				h_next.cs_n = 1'b1;
				if (h_reg.div == 4'h0) begin
					h_next.st = smspi_pkg::SMSPI_H_IDLE;
				end
			end
			default: begin
				h_next.st = smspi_pkg::SMSPI_H_IDLE;
			end
		endcase
		// Within a selection a further byte continues without a new select.
		if (h_reg.st == smspi_pkg::SMSPI_H_IDLE && !h_reg.cs_n) begin
			h_next.sck = 1'b0;
			if (start_i) begin
				h_next.cs_n = 1'b0;
			end
		end
		// Busy is registered so the output comes straight from a flop.
		h_next.busy = (h_next.st != smspi_pkg::SMSPI_H_IDLE);
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			h_reg <= '{st: smspi_pkg::SMSPI_H_IDLE, cs_n: 1'b1, wp_n: 1'b1, default: '0};
		end else if (ce_i) begin
			h_reg <= h_next;
		end
	end

	assign link.cs_n = h_reg.cs_n;
	assign link.sck = h_reg.sck;
	assign link.mosi = h_reg.mosi;
	assign link.wp_n = h_reg.wp_n;
	assign busy_o = h_reg.busy;
	assign byte_done_o = h_reg.done;
	assign rx_byte_o = h_reg.rx_out;
endmodule // smspi_host

// *** test/smspi_sva.sv ***
// Checker for the signals of the serial memory link.
`timescale 1ns/100ps
module smspi_sva (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic mosi,
	input wire logic miso_o,
	input wire logic miso_oe
);
	// ==========================================================
	// Helper logic
	logic sck_d_reg;
	logic cs_d_reg;
	logic [7:0] rise_reg;
	// Counts serial clock rises within one selection; it saturates so long frames never wrap.
	always_ff @(posedge core_clk_i) begin
		sck_d_reg <= sck;
		cs_d_reg <= cs_n;
		if (reset_i || (cs_d_reg && !cs_n)) begin
			rise_reg <= 8'h00;
		end else if (sck && !sck_d_reg && !cs_n && rise_reg != 8'hFF) begin
			rise_reg <= rise_reg + 8'h01;
		end
	end
	// ==========================================================
	// Assertions
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (reset_i);
	standby_out_off_a: assert property (cs_n [*5] |-> !miso_oe)
		else $error("Serial output driven while deselected.");
	release_out_a: assert property ($rose(cs_n) |-> ##[1:4] !miso_oe)
		else $error("Serial output not released after deselect.");
	out_change_low_a: assert property (miso_oe && $changed(miso_o) |-> !sck)
		else $error("Serial output changed while the clock was high.");
	mosi_hold_a: assert property ($rose(sck) && !cs_n |-> $stable(mosi) ##1 $stable(mosi) [*3])
		else $error("Serial input moved around a rising clock edge.");
	quiet_start_a: assert property ($fell(cs_n) |=> $stable(sck) [*3])
		else $error("Serial clock moved right at selection.");
	whole_bytes_a: assert property ($rose(cs_n) |-> rise_reg[2:0] == 3'h0 && rise_reg != 8'h00)
		else $error("Selection ended inside a byte.");
	deselect_gap_a: assert property ($rose(cs_n) |=> cs_n [*4])
		else $error("Selection restarted too soon.");
	drive_after_op_a: assert property ($rose(miso_oe) |-> rise_reg >= 8'h08)
		else $error("Serial output driven before the opcode ended.");
	clock_high_a: assert property ($rose(sck) && !cs_n |=> sck [*4])
		else $error("Serial clock high phase too short.");
	// Main scenarios reached.
	cover property ($rose(miso_oe));
	cover property ($fell(cs_n) && sck);
	cover property ($rose(cs_n) && rise_reg >= 8'h28);
endmodule // smspi_sva

// *** test/smspi_tb_top.sv ***
// Testbench joining the host and device ends of the serial memory link.
`timescale 1ns/100ps
module smspi_tb_top;
	logic core_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic start_i = 1'b0;
	logic [7:0] tx_byte_i = 8'h00;
	logic last_i = 1'b0;
	logic mode3_i = 1'b0;
	logic wp_n_i = 1'b1;
	logic busy_o;
	logic byte_done_o;
	logic [7:0] rx_byte_o;
	logic selected_o;
	logic [7:0] status_o;
	logic write_enable_o;
	logic spi_mode3_o;
	logic sck_q = 1'b0;
	logic [7:0] wire_sh = 8'h00;
	logic [7:0] lock = 8'h00;
	logic [7:0] rxq[$];
	int failures = 0;
	int tests_run = 0;
	// ==========================================================
	// Clock and instances
	// Core clock toggles every half period.
	always #25 core_clk_i = ~core_clk_i;
	smspi_if smspi_if_i ();
	smspi_device smspi_device_i (.core_clk_i(core_clk_i), .reset_i(reset_i), .ce_i(1'b1),
		.link(smspi_if_i.device), .selected_o(selected_o), .status_o(status_o),
		.write_enable_o(write_enable_o), .spi_mode3_o(spi_mode3_o));
	smspi_host smspi_host_i (.core_clk_i(core_clk_i), .reset_i(reset_i), .ce_i(1'b1),
		.link(smspi_if_i.host), .start_i(start_i), .tx_byte_i(tx_byte_i), .last_i(last_i),
		.mode3_i(mode3_i), .wp_n_i(wp_n_i), .busy_o(busy_o), .byte_done_o(byte_done_o),
		.rx_byte_o(rx_byte_o));
	smspi_sva smspi_sva_i (.core_clk_i(core_clk_i), .reset_i(reset_i), .cs_n(smspi_if_i.cs_n),
		.sck(smspi_if_i.sck), .mosi(smspi_if_i.mosi), .miso_o(smspi_if_i.miso_o),
		.miso_oe(smspi_if_i.miso_oe));
	// Wire monitor shifts the data line at each clock rise, independent of both ends.
	always @(posedge core_clk_i) begin
		sck_q <= smspi_if_i.sck;
		if (smspi_if_i.sck && !sck_q) begin
			wire_sh <= {wire_sh[6:0], smspi_if_i.mosi};
		end
	end
	// ==========================================================
	// Tasks
	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk1(input string what, input logic exp, input logic got);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("FAIL %s expected %b seen %b", what, exp, got);
		end
	endtask
	// Bounded wait for a done pulse or for the host to go idle; a hang ends the run.
	task automatic spin(input bit want_done);
		int k;
		k = 0;
		while ((want_done ? byte_done_o : !busy_o) !== 1'b1) begin
			@(negedge core_clk_i);
			k++;
			if (k > 300) begin
				failures++;
				$display("FAIL handshake expected 1 seen timeout");
				finish_test();
			end
		end
	endtask
	// One selection: each byte is a separate request, the last one ends the selection.
	task automatic frame(input logic [7:0] q[$]);
		rxq.delete();
		foreach (q[i]) begin
			if (i != 0) begin
				// A long gap inside the selection stands for a paused serial clock.
				repeat (20) @(negedge core_clk_i);
			end
			spin(1'b0);
			start_i = 1'b1;
			tx_byte_i = q[i];
			last_i = (i == q.size() - 1);
			@(negedge core_clk_i);
			start_i = 1'b0;
			spin(1'b1);
			rxq.push_back(rx_byte_o);
			chk8("wire byte", q[i], wire_sh);
			chk1("device selected", 1'b1, selected_o);
		end
		spin(1'b0);
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		repeat (2) @(negedge core_clk_i);
		reset_i = 1'b0;
		lock[smspi_pkg::SMSPI_LOCK_BIT] = 1'b1;
		chk8("status after reset", smspi_pkg::SMSPI_STATUS_RST, status_o);
		chk1("latch after reset", 1'b0, write_enable_o);
		chk1("output enable idle", 1'b0, smspi_if_i.miso_oe);
		frame('{smspi_pkg::SMSPI_OP_WREN});
		chk1("latch after set", 1'b1, write_enable_o);
		frame('{smspi_pkg::SMSPI_OP_WRITE, 8'hE7, 8'hFF, 8'hFE, 8'hC1, 8'h36});
		frame('{smspi_pkg::SMSPI_OP_READ, 8'h07, 8'hFF, 8'hFE, 8'h00, 8'h00});
		for (int i = 0; i < 4; i++) begin
			chk8("undriven line", 8'hFF, rxq[i]);
		end
		chk8("read byte 0", 8'hC1, rxq[4]);
		chk8("read byte 1", 8'h36, rxq[5]);
		frame('{8'hAB, 8'h11, 8'h22});
		chk8("ignored byte 1", 8'hFF, rxq[1]);
		chk8("ignored byte 2", 8'hFF, rxq[2]);
		frame('{smspi_pkg::SMSPI_OP_RDSR, 8'h00});
		chk8("status read", smspi_pkg::SMSPI_STATUS_RST, rxq[1]);
		frame('{smspi_pkg::SMSPI_OP_WREN});
		frame('{smspi_pkg::SMSPI_OP_WRSR, lock});
		chk8("status locked", lock, status_o);
		wp_n_i = 1'b0;
		frame('{smspi_pkg::SMSPI_OP_WREN});
		frame('{smspi_pkg::SMSPI_OP_WRSR, 8'h00});
		chk8("status guarded", lock, status_o);
		frame('{smspi_pkg::SMSPI_OP_RDSR, 8'h00});
		chk8("status read locked", lock, rxq[1]);
		wp_n_i = 1'b1;
		frame('{smspi_pkg::SMSPI_OP_WREN});
		frame('{smspi_pkg::SMSPI_OP_WRSR, 8'h00});
		chk8("status unlocked", 8'h00, status_o);
		frame('{smspi_pkg::SMSPI_OP_WREN});
		frame('{smspi_pkg::SMSPI_OP_WRDI});
		chk1("latch after clear", 1'b0, write_enable_o);
		frame('{smspi_pkg::SMSPI_OP_WRITE, 8'h07, 8'hFF, 8'hFE, 8'h77});
		frame('{smspi_pkg::SMSPI_OP_READ, 8'h07, 8'hFF, 8'hFE, 8'h00});
		chk8("unlatched write", 8'hC1, rxq[4]);
		mode3_i = 1'b1;
		// Let the idle clock level settle before the next selection.
		repeat (2) @(negedge core_clk_i);
		frame('{smspi_pkg::SMSPI_OP_WREN});
		frame('{smspi_pkg::SMSPI_OP_WRITE, 8'h00, 8'h00, 8'h10, 8'h5A});
		frame('{smspi_pkg::SMSPI_OP_READ, 8'h00, 8'h00, 8'h10, 8'h00});
		chk1("mode 3 seen", 1'b1, spi_mode3_o);
		chk8("mode 3 read", 8'h5A, rxq[4]);
		mode3_i = 1'b0;
		repeat (2) @(negedge core_clk_i);
		frame('{smspi_pkg::SMSPI_OP_RDSR, 8'h00});
		chk1("mode 0 seen", 1'b0, spi_mode3_o);
		finish_test();
	end
endmodule // smspi_tb_top
